/* rtl/bcf_pkg.sv */
// shared types and constants for the bus command and format interpreter
package bcf_pkg;
  localparam int VAL_W       = 48;   // entered value, units of 1e-7
  localparam int MANT_W      = 32;
  localparam int EXP_W       = 6;
  localparam int FRAC_DIGITS = 7;    // fixed decimals held in a value
  localparam int POW_MAX     = 14;   // largest decimal scale accepted
  localparam int RD_W        = 32;   // reading code width
  localparam int LOC_W       = 10;
  localparam int FIFO_DEPTH  = 32;

  localparam logic [VAL_W-1:0] CAL_LIMIT_COUNTS = 48'h0000_0021_91C0;
  localparam logic [LOC_W-1:0] BUF_SIZE_MAX     = 10'h1F4;
  localparam logic [LOC_W-1:0] LOC_FIRST        = 10'h001;
  localparam logic [23:0]      FAST_IVL_MAX     = 24'h000004;
  localparam logic [15:0]      FAST_FUNC_MASK   = 16'h019B;
  localparam logic [2:0]       FMT_DEFAULT      = 3'h0;
  localparam logic [2:0]       FMT_WHOLE_FIRST  = 3'h2;
  localparam logic [2:0]       FMT_LOC_LAST     = 3'h3;
  localparam logic [2:0]       FMT_MAX          = 3'h5;
  localparam logic             SRC_DEFAULT      = 1'b0;
  localparam logic [2:0]       LOWEST_RANGE     = 3'h0;
  localparam logic [3:0]       THERMO_FUNC      = 4'h9;
  localparam logic [23:0]      PARAM_ONE        = 24'h000001;

  typedef enum logic [3:0] {
    CMD_VALUE, CMD_CAL, CMD_DEFAULTS, CMD_FORMAT, CMD_SOURCE,
    CMD_INTERVAL, CMD_SIZE, CMD_FUNCTION, CMD_RANGE
  } bcf_cmd_e;

  typedef enum logic [2:0] {
    TOK_PREFIX, TOK_READING, TOK_COMMA, TOK_LOC_B, TOK_LOC, TOK_TERM
  } bcf_tok_e;

  typedef struct packed {
    bcf_cmd_e                  code;
    logic [23:0]               param;
    logic signed [MANT_W-1:0]  mant;
    logic signed [EXP_W-1:0]   expo;
  } bcf_cmd_s;

  typedef struct packed {
    logic [2:0]       fmt;
    logic             src;       // 1 = reading buffer
    logic [23:0]      interval;
    logic [LOC_W-1:0] size;
    logic [3:0]       func;
    logic [2:0]       rng;
  } bcf_state_s;

  typedef struct packed {
    bcf_tok_e         kind;
    logic [RD_W-1:0]  data;
  } bcf_tok_s;

  typedef struct packed {
    logic [VAL_W-1:0] full_pt;
    logic [VAL_W-1:0] zero_pt;
    logic [2:0]       rng;
  } bcf_cal_s;

  localparam bcf_state_s FACTORY = '{fmt: 3'h0, src: 1'b0,
    interval: 24'h0, size: 10'h0, func: 4'h0, rng: 3'h0};

  function automatic logic [VAL_W-1:0] pow10(input logic [3:0] n);
    logic [VAL_W-1:0] p;
    p = VAL_W'(1);
    for (int i = 0; i < POW_MAX; i++) begin
      if (i < int'(n)) p = VAL_W'(p * VAL_W'(10));
    end
    return p;
  endfunction : pow10
endpackage : bcf_pkg

/* rtl/bcf_core.sv */
// command interpreter, calibration, defaults and reading formatter

////////////////////////////////////////////////////////////////////////////
// reading fifo
module bcf_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 32
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;

  // pointers wrap naturally, so depth must be a power of two
  wire logic        push     = in_valid && in_ready;
  wire logic        pop      = out_valid && out_ready;
  wire logic [AW:0] next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data = mem[rp];

  always_ff @(posedge clk_sys) begin
    if (push) mem[wp] <= in_data;
  end

  // flags registered so full and empty never glitch
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wp        <= '0;
      rp        <= '0;
      cnt       <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      wp        <= wp + AW'(push);
      rp        <= rp + AW'(pop);
      cnt       <= next_cnt;
      in_ready  <= next_cnt != (AW+1)'(DEPTH);
      out_valid <= next_cnt != '0;
    end
  end
endmodule : bcf_fifo

////////////////////////////////////////////////////////////////////////////
// top
module bcf_core (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire logic                      cmd_valid,
  input  wire bcf_pkg::bcf_cmd_s         cmd,
  input  wire logic                      dev_clear,
  input  wire logic                      cal_unlocked,
  input  wire logic                      rd_valid,
  input  wire logic [bcf_pkg::RD_W-1:0]  rd_data,
  output logic                           rd_ready,
  input  wire logic                      talk,
  input  wire logic [bcf_pkg::LOC_W-1:0] buf_count,
  output logic                           tok_valid,
  output bcf_pkg::bcf_tok_s              tok,
  input  wire logic                      tok_ready,
  output logic [bcf_pkg::LOC_W-1:0]      buf_addr,
  output bcf_pkg::bcf_state_s            state,
  output logic                           state_save,
  output logic                           cal_write,
  output bcf_pkg::bcf_cal_s              cal,
  output logic [bcf_pkg::VAL_W-1:0]      entered_value,
  output logic [bcf_pkg::VAL_W-1:0]      zero_offset,
  output logic [bcf_pkg::VAL_W-1:0]      ref_junction,
  output logic                           illegal_option_error,
  output logic                           cal_locked_error,
  output logic                           talk_busy
);
  typedef enum logic [2:0] {
    S_IDLE, S_PREFIX, S_READ, S_COMMA, S_LOC, S_SEP, S_TERM
  } bcf_fsm_e;

  localparam int VW = bcf_pkg::VAL_W;
  bcf_fsm_e                  st;
  bcf_fsm_e                  next_st;
  logic [bcf_pkg::RD_W-1:0]  cur;
  logic [bcf_pkg::LOC_W-1:0] cur_loc;
  logic [bcf_pkg::LOC_W-1:0] n_sent;
  logic                      p1_valid;
  logic                      f_valid;
  logic [bcf_pkg::RD_W-1:0]  f_data;
  logic                      pop;
  logic                      emit;
  logic                      end_talk;
  bcf_pkg::bcf_tok_s         etok;

  bcf_fifo #(.W(bcf_pkg::RD_W), .DEPTH(bcf_pkg::FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (rd_valid),
    .in_data   (rd_data),
    .in_ready  (rd_ready),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (pop)
  );

  //////////////////////////////////////////////////////////////////////////
  // command decode
  wire logic is_val = cmd_valid && cmd.code == bcf_pkg::CMD_VALUE;
  wire logic is_cal = cmd_valid && cmd.code == bcf_pkg::CMD_CAL;
  wire logic is_def = cmd_valid && cmd.code == bcf_pkg::CMD_DEFAULTS;
  wire logic is_fmt = cmd_valid && cmd.code == bcf_pkg::CMD_FORMAT;
  wire logic is_src = cmd_valid && cmd.code == bcf_pkg::CMD_SOURCE;
  wire logic is_ivl = cmd_valid && cmd.code == bcf_pkg::CMD_INTERVAL;
  wire logic is_siz = cmd_valid && cmd.code == bcf_pkg::CMD_SIZE;
  wire logic is_fun = cmd_valid && cmd.code == bcf_pkg::CMD_FUNCTION;
  wire logic is_rng = cmd_valid && cmd.code == bcf_pkg::CMD_RANGE;
  wire logic p_zero = cmd.param == '0;
  wire logic p_one  = cmd.param == bcf_pkg::PARAM_ONE;

  // mantissa scaled to fixed decimals; both written forms meet here
  wire logic signed [bcf_pkg::EXP_W:0] exp_adj =
    $signed({cmd.expo[bcf_pkg::EXP_W-1], cmd.expo})
    + (bcf_pkg::EXP_W+1)'(bcf_pkg::FRAC_DIGITS);
  wire logic val_ok = exp_adj >= 0
    && exp_adj <= (bcf_pkg::EXP_W+1)'(bcf_pkg::POW_MAX);
  wire logic signed [VW-1:0] mant_x = VW'(cmd.mant);
  wire logic signed [VW-1:0] scaled =
    VW'(mant_x * $signed(bcf_pkg::pow10(exp_adj[3:0])));

  // cal limit scaled by range decade; magnitude of held value
  wire logic [VW-1:0] cal_mag = entered_value[VW-1]
    ? VW'(-entered_value) : entered_value;
  wire logic [VW-1:0] cal_lim =
    VW'(bcf_pkg::CAL_LIMIT_COUNTS * bcf_pkg::pow10({1'b0, state.rng}));
  wire logic cal_over = cal_mag > cal_lim;
  wire logic cal_bad  = cal_over || !(p_zero || p_one)
    || (p_one && !p1_valid);

  // fast interval legality, checked against the setting being changed
  wire logic ivl_fast = !p_zero && cmd.param <= bcf_pkg::FAST_IVL_MAX;
  wire logic cur_fast = state.interval != '0
    && state.interval <= bcf_pkg::FAST_IVL_MAX;
  wire logic fast_env = bcf_pkg::FAST_FUNC_MASK[state.func]
    && state.rng != bcf_pkg::LOWEST_RANGE;
  wire logic ivl_bad  = ivl_fast && (state.size == '0 || !fast_env);
  wire logic siz_bad  = cmd.param > 24'(bcf_pkg::BUF_SIZE_MAX)
    || (p_zero && cur_fast);
  wire logic fun_bad  = cur_fast
    && !bcf_pkg::FAST_FUNC_MASK[cmd.param[3:0]];
  wire logic rng_bad  = cur_fast
    && cmd.param[2:0] == bcf_pkg::LOWEST_RANGE;
  wire logic fmt_bad  = cmd.param > 24'(bcf_pkg::FMT_MAX);
  wire logic opt_bad  = (is_val && !val_ok)
    || (is_cal && cal_unlocked && cal_bad)
    || (is_def && !(p_zero || p_one))
    || (is_src && !(p_zero || p_one))
    || (is_fmt && fmt_bad) || (is_ivl && ivl_bad)
    || (is_siz && siz_bad) || (is_fun && fun_bad)
    || (is_rng && rng_bad);

  //////////////////////////////////////////////////////////////////////////
  // value, zero offset, junction reference
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      entered_value <= '0;
      zero_offset   <= '0;
      ref_junction  <= '0;
    end else if (is_val && val_ok) begin
      entered_value <= scaled;
      if (state.func == bcf_pkg::THERMO_FUNC) ref_junction <= scaled;
      else zero_offset <= scaled;
    end
  end

  // two-point calibration, committed only on the second point
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cal       <= '0;
      p1_valid  <= 1'b0;
      cal_write <= 1'b0;
    end else begin
      cal_write <= 1'b0;
      if (is_cal && cal_unlocked && !cal_bad) begin
        if (p_zero) begin
          cal.full_pt <= entered_value;
          cal.rng     <= state.rng;
          p1_valid    <= 1'b1;
        end else begin
          cal.zero_pt <= entered_value;
          p1_valid    <= 1'b0;
          cal_write   <= 1'b1;
        end
      end
    end
  end

  // error pulses
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      illegal_option_error <= 1'b0;
      cal_locked_error     <= 1'b0;
    end else begin
      illegal_option_error <= opt_bad;
      cal_locked_error     <= is_cal && !cal_unlocked;
    end
  end

  // operating state; device clear wins over a same-cycle command
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state      <= bcf_pkg::FACTORY;
      state_save <= 1'b0;
    end else begin
      state_save <= is_def && (p_zero || p_one);
      if (dev_clear) begin
        state.fmt <= bcf_pkg::FMT_DEFAULT;
        state.src <= bcf_pkg::SRC_DEFAULT;
      end else if (!opt_bad) begin
        if (is_def && p_zero) state <= bcf_pkg::FACTORY;
        if (is_fmt) state.fmt <= cmd.param[2:0];
        if (is_src) state.src <= cmd.param[0];
        if (is_ivl) state.interval <= cmd.param;
        if (is_siz) state.size <= cmd.param[bcf_pkg::LOC_W-1:0];
        if (is_fun) state.func <= cmd.param[3:0];
        if (is_rng) state.rng <= cmd.param[2:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // formatter decode
  wire logic whole   = state.fmt >= bcf_pkg::FMT_WHOLE_FIRST;
  wire logic pfx_en  = !state.fmt[0];
  wire logic loc_en  = state.fmt <= bcf_pkg::FMT_LOC_LAST && state.src;
  wire logic slot    = !tok_valid || tok_ready;
  wire logic last    = !state.src || n_sent == buf_count;
  // converter data in whole mode stops without a terminator
  wire logic no_term = whole && !state.src;
  wire bcf_fsm_e after_rec = (!whole || (last && !no_term)) ? S_TERM
    : last ? S_IDLE : S_SEP;
  wire logic [bcf_pkg::LOC_W-1:0] addr_inc = (buf_addr >= buf_count)
    ? bcf_pkg::LOC_FIRST : buf_addr + bcf_pkg::LOC_FIRST;

  // one token per step, held while the sink stalls
  always_comb begin
    next_st  = st;
    emit     = 1'b0;
    pop      = 1'b0;
    end_talk = 1'b0;
    etok     = '{kind: bcf_pkg::TOK_COMMA, data: '0};
    case (st)
      S_IDLE: begin
        if (talk_busy && f_valid) begin
          pop     = 1'b1;
          next_st = pfx_en ? S_PREFIX : S_READ;
        end
      end
      S_PREFIX: begin
        emit    = slot;
        etok    = '{kind: bcf_pkg::TOK_PREFIX,
                    data: bcf_pkg::RD_W'(state.func)};
        next_st = slot ? S_READ : st;
      end
      S_READ: begin
        emit     = slot;
        etok     = '{kind: bcf_pkg::TOK_READING, data: cur};
        next_st  = !slot ? st : loc_en ? S_COMMA : after_rec;
        end_talk = slot && !loc_en && after_rec == S_IDLE;
      end
      S_COMMA: begin
        emit    = slot;
        next_st = slot ? S_LOC : st;
      end
      S_LOC: begin
        emit     = slot;
        etok     = '{kind: pfx_en ? bcf_pkg::TOK_LOC_B
                    : bcf_pkg::TOK_LOC,
                    data: bcf_pkg::RD_W'(cur_loc)};
        next_st  = slot ? after_rec : st;
        end_talk = slot && after_rec == S_IDLE;
      end
      S_SEP: begin
        emit    = slot;
        next_st = slot ? S_IDLE : st;
      end
      S_TERM: begin
        emit     = slot;
        etok     = '{kind: bcf_pkg::TOK_TERM, data: '0};
        next_st  = slot ? S_IDLE : st;
        end_talk = slot;
      end
      default: next_st = S_IDLE;
    endcase
  end

  // talk session and record capture
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st        <= S_IDLE;
      talk_busy <= 1'b0;
      cur       <= '0;
      cur_loc   <= bcf_pkg::LOC_FIRST;
      n_sent    <= '0;
    end else begin
      st <= next_st;
      if (end_talk) talk_busy <= 1'b0;
      else if (talk) talk_busy <= 1'b1;
      if (end_talk) n_sent <= '0;
      else if (pop) n_sent <= n_sent + bcf_pkg::LOC_FIRST;
      if (pop) begin
        cur     <= f_data;
        cur_loc <= buf_addr;
      end
    end
  end

  // buffer location walk; a source command selecting the buffer restarts it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) buf_addr <= bcf_pkg::LOC_FIRST;
    else if (is_src && cmd.param[0]) buf_addr <= bcf_pkg::LOC_FIRST;
    else if (pop && state.src) buf_addr <= addr_inc;
  end

  // token output register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tok_valid <= 1'b0;
      tok       <= '{kind: bcf_pkg::TOK_COMMA, data: '0};
    end else if (slot) begin
      tok_valid <= emit;
      tok       <= etok;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  property p_value_held;
    @(posedge clk_sys) disable iff (rst)
    is_val && val_ok |=> entered_value == $past(scaled);
  endproperty
  a_value_held: assert property (p_value_held)
    else $error("entered value not the scaled command value");

  property p_cal_limit;
    @(posedge clk_sys) disable iff (rst)
    is_cal && cal_unlocked && cal_over |=> illegal_option_error && !cal_write;
  endproperty
  a_cal_limit: assert property (p_cal_limit)
    else $error("over-limit calibration not refused");

  property p_cal_lock;
    @(posedge clk_sys) disable iff (rst)
    cal_write |-> $past(cal_unlocked) && $past(is_cal);
  endproperty
  a_cal_lock: assert property (p_cal_lock)
    else $error("calibration committed while locked");

  property p_cal_two;
    @(posedge clk_sys) disable iff (rst)
    cal_write |-> $past(p1_valid) && !p1_valid;
  endproperty
  a_cal_two: assert property (p_cal_two)
    else $error("commit without a first point");

  property p_clear_fmt;
    @(posedge clk_sys) disable iff (rst)
    dev_clear |=> state.fmt == bcf_pkg::FMT_DEFAULT;
  endproperty
  a_clear_fmt: assert property (p_clear_fmt)
    else $error("format not defaulted by device clear");

  property p_factory;
    @(posedge clk_sys) disable iff (rst)
    is_def && p_zero && !dev_clear |=> state == bcf_pkg::FACTORY && state_save;
  endproperty
  a_factory: assert property (p_factory)
    else $error("factory restore failed");

  property p_fast_size;
    @(posedge clk_sys) disable iff (rst)
    is_ivl && ivl_fast && state.size == '0
      |=> illegal_option_error && $stable(state.interval);
  endproperty
  a_fast_size: assert property (p_fast_size)
    else $error("fast interval taken with continuous size");

  property p_no_term;
    @(posedge clk_sys) disable iff (rst)
    tok_valid && tok.kind == bcf_pkg::TOK_TERM
      |-> !(state.fmt >= bcf_pkg::FMT_WHOLE_FIRST && !state.src);
  endproperty
  a_no_term: assert property (p_no_term)
    else $error("terminator sent for converter whole-buffer data");

  property p_restart;
    @(posedge clk_sys) disable iff (rst)
    is_src && cmd.param[0] |=> buf_addr == bcf_pkg::LOC_FIRST;
  endproperty
  a_restart: assert property (p_restart)
    else $error("buffer walk not restarted at first location");
endmodule : bcf_core

/* verification/bcf_far_model.sv */
// far-side model: reading source and talker-side token sink
module bcf_far_model (
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                slow,
  input  wire logic                rd_ready,
  output logic                     rd_valid,
  output logic [bcf_pkg::RD_W-1:0] rd_data,
  input  wire logic                tok_valid,
  input  wire bcf_pkg::bcf_tok_s   tok,
  output logic                     tok_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  bcf_pkg::bcf_tok_s got[$];
  logic [1:0]        beat;
  // a reading only moves on once taken, so none is lost or repeated
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_valid <= 1'b0;
      rd_data <= 32'h0;
    end else begin
      rd_valid <= 1'b1;
      if (rd_valid && rd_ready) rd_data <= rd_data + 32'h1;
    end
  end
  // slow mode stalls half the time to prove tokens are held
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      beat <= 2'h0;
      tok_ready <= 1'b0;
    end else begin
      beat <= beat + 2'h1;
      tok_ready <= !slow || beat[1];
      if (tok_valid && tok_ready) got.push_back(tok);
    end
  end
endmodule : bcf_far_model

/* verification/tb_bus_cal_default_format_cmds.sv */
// self-checking bench for the command interpreter and reading formatter
module tb_bus_cal_default_format_cmds;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, rst = 1'b1, cmd_valid = 1'b0, dev_clear = 1'b0;
  logic cal_unlocked = 1'b0, talk = 1'b0, slow = 1'b0;
  logic [9:0] buf_count = 10'h002;
  bcf_pkg::bcf_cmd_s cmd = '0;
  logic rd_valid, rd_ready, tok_valid, tok_ready, state_save, cal_write;
  logic illegal_option_error, cal_locked_error, talk_busy;
  logic [31:0] rd_data;
  logic [9:0] buf_addr;
  logic [47:0] entered_value, zero_offset, ref_junction;
  bcf_pkg::bcf_tok_s tok;
  bcf_pkg::bcf_state_s state;
  bcf_pkg::bcf_cal_s cal;
  logic err, lck, cw, ss;
  int errors = 0, samples_checked = 0, cyc = 0, rd_next = 0;
  always #2 clk_sys = ~clk_sys;
  bcf_core dut (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid),
    .cmd(cmd), .dev_clear(dev_clear), .cal_unlocked(cal_unlocked),
    .rd_valid(rd_valid), .rd_data(rd_data), .rd_ready(rd_ready),
    .talk(talk), .buf_count(buf_count), .tok_valid(tok_valid), .tok(tok),
    .tok_ready(tok_ready), .buf_addr(buf_addr), .state(state),
    .state_save(state_save), .cal_write(cal_write), .cal(cal),
    .entered_value(entered_value), .zero_offset(zero_offset),
    .ref_junction(ref_junction), .talk_busy(talk_busy),
    .illegal_option_error(illegal_option_error),
    .cal_locked_error(cal_locked_error));
  bcf_far_model far (.clk_sys(clk_sys), .rst(rst), .slow(slow),
    .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .tok_valid(tok_valid), .tok(tok), .tok_ready(tok_ready));
  ////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [47:0] x, logic [47:0] g);
    samples_checked++;
    if (g !== x) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  // one command pulse, then capture the one-cycle answer pulses
  // while they stand, just after the edge that takes the command
  task automatic send(bcf_pkg::bcf_cmd_e c, int p, int m = 0, int e = 0);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd <= '{code: c, param: 24'(p), mant: 32'(m), expo: 6'(e)};
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    #1;
    {err, lck, cw, ss} = {illegal_option_error, cal_locked_error,
                          cal_write, state_save};
  endtask : send
  task automatic sx(bcf_pkg::bcf_cmd_e c, int p, int m, int e, logic x);
    send(c, p, m, e);
    chk("illegal_option_error", x, err);
  endtask : sx
  ////////////////////////////////////////////////////////////////////////
  task automatic t_value();
    send(bcf_pkg::CMD_VALUE, 0, 20, 0);
    chk("entered_value", 48'h0000_0BEB_C200, entered_value);
    chk("zero_offset", 48'h0000_0BEB_C200, zero_offset);
    send(bcf_pkg::CMD_VALUE, 0, 2, 1);
    chk("entered_value", 48'h0000_0BEB_C200, entered_value);
    sx(bcf_pkg::CMD_VALUE, 0, 5, -8, 1'b1);
    chk("entered_value", 48'h0000_0BEB_C200, entered_value);
    send(bcf_pkg::CMD_FUNCTION, 9);
    send(bcf_pkg::CMD_VALUE, 0, -25, -1);
    chk("ref_junction", 48'(-25000000), ref_junction);
    chk("zero_offset", 48'h0000_0BEB_C200, zero_offset);
    send(bcf_pkg::CMD_FUNCTION, 0);
    chk("entered_value", 48'(-25000000), entered_value);
    $display("test value done");
  endtask : t_value
  task automatic t_cal();
    send(bcf_pkg::CMD_RANGE, 2);
    send(bcf_pkg::CMD_VALUE, 0, 2, 0);
    send(bcf_pkg::CMD_CAL, 0);
    chk("cal_locked_error", 1'b1, lck);
    cal_unlocked <= 1'b1;
    sx(bcf_pkg::CMD_CAL, 1, 0, 0, 1'b1);
    chk("cal_write", 1'b0, cw);
    send(bcf_pkg::CMD_CAL, 0);
    chk("cal_write", 1'b0, cw);
    chk("full_pt", 48'd20000000, cal.full_pt);
    send(bcf_pkg::CMD_VALUE, 0, 0, 0);
    send(bcf_pkg::CMD_CAL, 1);
    chk("cal_write", 1'b1, cw);
    chk("zero_pt", 48'h0, cal.zero_pt);
    chk("cal_range", 3'h2, cal.rng);
    send(bcf_pkg::CMD_VALUE, 0, 220000001, -7);
    sx(bcf_pkg::CMD_CAL, 0, 0, 0, 1'b1);
    send(bcf_pkg::CMD_VALUE, 0, 22, 0);
    sx(bcf_pkg::CMD_CAL, 0, 0, 0, 1'b0);
    $display("test calibration done");
  endtask : t_cal
  task automatic t_fast();
    sx(bcf_pkg::CMD_INTERVAL, 1, 0, 0, 1'b1);
    sx(bcf_pkg::CMD_SIZE, 501, 0, 0, 1'b1);
    sx(bcf_pkg::CMD_SIZE, 500, 0, 0, 1'b0);
    send(bcf_pkg::CMD_FUNCTION, 2);
    sx(bcf_pkg::CMD_INTERVAL, 2, 0, 0, 1'b1);
    send(bcf_pkg::CMD_FUNCTION, 8);
    sx(bcf_pkg::CMD_INTERVAL, 4, 0, 0, 1'b0);
    chk("interval", 24'h4, state.interval);
    sx(bcf_pkg::CMD_SIZE, 0, 0, 0, 1'b1);
    sx(bcf_pkg::CMD_RANGE, 0, 0, 0, 1'b1);
    send(bcf_pkg::CMD_DEFAULTS, 1);
    chk("state_save", 1'b1, ss);
    chk("interval", 24'h4, state.interval);
    send(bcf_pkg::CMD_DEFAULTS, 0);
    chk("state_save", 1'b1, ss);
    chk("state", bcf_pkg::FACTORY, state);
    sx(bcf_pkg::CMD_DEFAULTS, 2, 0, 0, 1'b1);
    sx(bcf_pkg::CMD_FORMAT, 6, 0, 0, 1'b1);
    send(bcf_pkg::CMD_FORMAT, 3);
    send(bcf_pkg::CMD_SOURCE, 1);
    @(posedge clk_sys);
    dev_clear <= 1'b1;
    @(posedge clk_sys);
    dev_clear <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("fmt", bcf_pkg::FMT_DEFAULT, state.fmt);
    $display("test modes and defaults done");
  endtask : t_fast
  // expected token stream of one talk session, two records for whole formats from the buffer, else one
  task automatic session(logic [2:0] f, logic s, int st);
    bcf_pkg::bcf_tok_s ex[$];
    int recs, c;
    far.got.delete();
    recs = (f >= 3'h2 && s) ? 2 : 1;
    for (int r = 0; r < recs; r++) begin
      if (!f[0]) ex.push_back('{bcf_pkg::TOK_PREFIX, 32'h0});
      ex.push_back('{bcf_pkg::TOK_READING, 32'(rd_next + r)});
      if (f <= 3'h3 && s) begin
        ex.push_back('{bcf_pkg::TOK_COMMA, 32'h0});
        ex.push_back('{f[0] ? bcf_pkg::TOK_LOC : bcf_pkg::TOK_LOC_B,
                       32'((st - 1 + r) % 2 + 1)});
      end
      if (r < recs - 1) ex.push_back('{bcf_pkg::TOK_COMMA, 32'h0});
    end
    if (f <= 3'h1 || s) ex.push_back('{bcf_pkg::TOK_TERM, 32'h0});
    @(posedge clk_sys);
    talk <= 1'b1;
    @(posedge clk_sys);
    talk <= 1'b0;
    // the last token may still sit stalled in the sink when talk ends
    for (c = 0; c < 400 && !(c > 3 && talk_busy === 1'b0
         && tok_valid === 1'b0); c++) begin
      @(posedge clk_sys);
      #1;
    end
    chk("session_end", 1'b1, c < 400);
    chk("token_count", ex.size(), far.got.size());
    foreach (ex[i]) if (i < far.got.size()) begin
      chk("token_kind", ex[i].kind, far.got[i].kind);
      chk("token_data", ex[i].data, far.got[i].data);
    end
    rd_next += recs;
    $display("session format %0d source %0d done", f, s);
  endtask : session
  task automatic t_format();
    chk("rd_ready", 1'b0, rd_ready);
    for (int f = 0; f < 6; f++) begin
      send(bcf_pkg::CMD_FORMAT, f);
      send(bcf_pkg::CMD_SOURCE, 1);
      slow <= f[0];
      session(3'(f), 1'b1, 1);
    end
    send(bcf_pkg::CMD_FORMAT, 1);
    send(bcf_pkg::CMD_SOURCE, 1);
    session(3'h1, 1'b1, 1);
    session(3'h1, 1'b1, 2);
    session(3'h1, 1'b1, 1);
    send(bcf_pkg::CMD_SOURCE, 0);
    send(bcf_pkg::CMD_FORMAT, 0);
    session(3'h0, 1'b0, 1);
    send(bcf_pkg::CMD_FORMAT, 2);
    session(3'h2, 1'b0, 1);
    $display("test formats done");
  endtask : t_format
  ////////////////////////////////////////////////////////////////////////
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      final_report();
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    t_value();
    t_cal();
    t_fast();
    t_format();
    final_report();
  end
endmodule : tb_bus_cal_default_format_cmds
